// ---- sim/pin_world.sv ----
// package pin and debug tool model beside the multiplexer
`timescale 1ns/1ps

module pin_world (
  input wire logic core_clk,
  input wire logic [7:0] port1_pin_out,
  input wire logic [7:0] port1_pin_oe,
  input wire logic [7:0] port2_pin_out,
  input wire logic [7:0] port2_pin_oe,
  input wire logic [7:0] ext1,
  input wire logic [7:0] ext2,
  input wire logic [7:0] extEn1,
  input wire logic [7:0] extEn2,
  input wire logic toolActive,
  input wire logic toolSel,
  output logic [7:0] port1_pin_in,
  output logic [7:0] port2_pin_in,
  output logic jtagSelect
);
  // ------------------------------------------------------------
  // wire resolution
  // ------------------------------------------------------------
  logic flip = 1'h0; // float pattern, no keeper on these pins
  // a floating pin must not look like a stable level
  always_ff @(posedge core_clk) begin
    flip <= ~flip;
  end
  // device drive first, then the board, else the float pattern
  assign port1_pin_in = (port1_pin_oe & port1_pin_out) |
    (~port1_pin_oe & extEn1 & ext1) | (~port1_pin_oe & ~extEn1 & {8{flip}});
  assign port2_pin_in = (port2_pin_oe & port2_pin_out) |
    (~port2_pin_oe & extEn2 & ext2) | (~port2_pin_oe & ~extEn2 & {8{flip}});
  // idle tool parks mode select high to stop sense current
  assign jtagSelect = toolActive ? toolSel : 1'h1;
endmodule : pin_world

// ---- sim/port_pin_function_mux_bench.sv ----
// self-checking bench for the port pin function multiplexer
`timescale 1ns/1ps

module port_pin_function_mux_bench;
  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  logic core_clk, rst, clkEn, testEnable, fuseBlown, jtagSelect;
  logic [7:0] port1_direction, port1_function_select;
  logic [7:0] port1_function_select_alt, port2_direction;
  logic [7:0] port2_function_select, port2_function_select_alt;
  logic [7:0] port1_out, port2_out, port1_pin_in, port2_pin_in;
  logic serial_transmit_line, converter1_bitstream_out;
  logic converter2_bitstream_out, spi_master_out_line;
  logic spi_master_in_out, spi_master_in_oe, serial_clock_out;
  logic serial_clock_oe, spi_master_out_oe, supervisor_output;
  logic timer_channel0_out, timer_channel1_out, timer_channel2_out;
  logic test_data_out, test_data_out_oe, hf_crystal_output;
  logic [7:0] port1_pin_out, port1_pin_oe, port2_pin_out, port2_pin_oe;
  logic [7:0] port1_in, port2_in, ext1, ext2, extEn1, extEn2;
  logic serial_receive_line, spi_master_in_line, spi_master_out_in;
  logic serial_clock_in, spi_slave_transmit_enable, hf_crystal_input;
  logic test_mode_select, test_clock_in, test_data_in, test_clock_input;
  logic jtagTakeover, testAccessAllowed, jtagBypass, memReadBlock;
  logic fuseCheckActive, fuse_sense_current, toolActive, toolSel;
  logic [15:0] src; // all peripheral sources in one word
  int errors = 0;
  int checked = 0;

  port_pin_function_mux port_pin_function_mux_i (.*);
  pin_world pin_world_i (.*);

  assign {serial_transmit_line, converter1_bitstream_out,
    converter2_bitstream_out, spi_master_out_line, spi_master_in_out,
    spi_master_in_oe, serial_clock_out, serial_clock_oe, spi_master_out_oe,
    supervisor_output, timer_channel0_out, timer_channel1_out,
    timer_channel2_out, test_data_out, test_data_out_oe,
    hf_crystal_output} = src;

  // 100 MHz clock
  initial begin
    core_clk = 1'h0;
    forever #5 core_clk = ~core_clk;
  end

  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task wt(input int n);
    repeat (n) @(negedge core_clk);
  endtask : wt

  task chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // controls change on the falling edge, two edges to land
  task set1(input logic [7:0] d, input logic [7:0] s, input logic [7:0] a);
    port1_direction = d;
    port1_function_select = s;
    port1_function_select_alt = a;
    wt(2);
  endtask : set1

  task set2(input logic [7:0] d, input logic [7:0] s, input logic [7:0] a);
    port2_direction = d;
    port2_function_select = s;
    port2_function_select_alt = a;
    wt(2);
  endtask : set2

  task do_reset;
    rst = 1'h1;
    wt(4);
    rst = 1'h0;
  endtask : do_reset

  task end_sim;
    $display("checks %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : end_sim

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  // every mode of pins 1.3 to 1.7, two source patterns each
  task t_port1;
    for (int p = 0; p < 2; p++) begin
      src = p ? 16'h43ac : 16'hb3d7;
      ext1 = p ? 8'ha5 : 8'h5a;
      port1_out = ~ext1;
      set1(8'hff, 8'h00, 8'h00);
      chk("p1 gpio oe", 8'hf8, port1_pin_oe & 8'hf8);
      chk("p1 gpio out", port1_out & 8'hf8, port1_pin_out & 8'hf8);
      set1(8'h00, 8'h00, 8'h00);
      chk("p1 gpio in", ext1 & 8'hf8, port1_in & 8'hf8);
      chk("p1 in oe", 8'h00, port1_pin_oe & 8'hf8);
      // primary functions must ignore the direction bit
      for (int d = 0; d < 2; d++) begin
        set1({8{d[0]}}, 8'hff, 8'h00);
        chk("p1 pri oe", {src[8], src[10], src[7], 2'h1, 3'h0},
          port1_pin_oe & 8'hf8);
        chk("p1 pri out", {src[9], 1'h0, src[12], 1'h0, src[15], 3'h0},
          port1_pin_out & 8'ha8);
        // pins 1.5 and 1.7 read back what the device itself drives
        chk("p1 pri rx", {4'h0, ext1[4], ext1[6], src[12], src[9]},
          {4'h0, serial_receive_line, spi_master_in_line, spi_master_out_in,
          serial_clock_in});
      end
      set1(8'hff, 8'hff, 8'hff);
      chk("p1 sec oe", 8'hf8, port1_pin_oe & 8'hf8);
      chk("p1 sec out", {src[4], src[3], src[6], src[13], src[14], 3'h0},
        port1_pin_out & 8'hf8);
      set1(8'h00, 8'hff, 8'hff);
      chk("p1 parked oe", 8'h00, port1_pin_oe & 8'hf8);
    end
    $display("t_port1 done");
  endtask : t_port1

  // a low enable freezes the pins although the controls move
  task t_freeze;
    set1(8'hff, 8'h00, 8'h00);
    clkEn = 1'h0;
    set1(8'h00, 8'hff, 8'h00);
    chk("frozen oe", 8'hf8, port1_pin_oe & 8'hf8);
    clkEn = 1'h1;
    wt(2);
    chk("thawed oe", {src[8], src[10], src[7], 2'h1, 3'h0},
      port1_pin_oe & 8'hf8);
    $display("t_freeze done");
  endtask : t_freeze

  // pin 2.0 modes and the crystal pins
  task t_port2;
    for (int p = 0; p < 2; p++) begin
      src = p ? 16'h43ac : 16'hb3d7;
      ext2 = p ? 8'h3e : 8'hc1;
      port2_out = ~ext2;
      set2(8'hff, 8'h00, 8'h00);
      chk("p2 gpio oe", 8'hc1, port2_pin_oe & 8'hc1);
      chk("p2 gpio out", port2_out & 8'hc1, port2_pin_out & 8'hc1);
      set2(8'h00, 8'hff, 8'h00);
      chk("p2 pri oe", 8'h80, port2_pin_oe & 8'hc1);
      chk("p2 xout", {src[0], 7'h0}, port2_pin_out & 8'h80);
      chk("p2 pri in", {6'h0, ext2[6], ext2[0]},
        {6'h0, hf_crystal_input, spi_slave_transmit_enable});
      chk("p2 in", ext2 & 8'h41, port2_in & 8'h41);
      set2(8'hff, 8'hff, 8'hff);
      chk("p2 sec", {6'h0, 1'h1, src[5]},
        {6'h0, port2_pin_oe[0], port2_pin_out[0]});
    end
    $display("t_port2 done");
  endtask : t_port2

  // test takeover overrides every select bit of its four pins
  task t_takeover;
    src = 16'hb3d7;
    set1(8'hff, 8'hff, 8'hff);
    testEnable = 1'h1;
    wt(10);
    chk("tk flags", 8'h06,
      {5'h0, jtagTakeover, testAccessAllowed, jtagBypass});
    chk("tk oe", {3'h0, src[1], 3'h0, 1'h1}, {3'h0, port1_pin_oe[7:5],
      port2_pin_oe[0], port1_pin_oe[3]});
    chk("tk in", {4'h0, ext1[5], ext1[6], ext2[0], ext2[0]},
      {4'h0, test_mode_select, test_clock_in, test_data_in,
      test_clock_input});
    testEnable = 1'h0;
    wt(10);
    chk("tk off", 8'h03, {6'h0, port1_pin_oe[6:5]});
    $display("t_takeover done");
  endtask : t_takeover

  // fuse check entry, sense gating, exit and power-on rearm
  task t_fuse;
    logic [4:0] selSeq;
    logic [9:0] expSeq;
    selSeq = 5'b01010;
    expSeq = 10'h03b;
    toolSel = 1'h1;
    wt(10);
    chk("fuse idle", 8'h00, {6'h0, fuseCheckActive,
      fuse_sense_current});
    for (int i = 0; i < 5; i++) begin
      toolSel = selSeq[i];
      wt(10);
      chk("fuse step", {6'h0, expSeq[2*i+:2]}, {6'h0, fuseCheckActive,
        fuse_sense_current});
    end
    do_reset;
    wt(10);
    chk("fuse held low", 8'h03,
      {6'h0, fuseCheckActive, fuse_sense_current});
    testEnable = 1'h1;
    wt(10);
    testEnable = 1'h0;
    wt(10);
    chk("fuse test end", 8'h00,
      {6'h0, fuseCheckActive, fuse_sense_current});
    toolSel = 1'h1;
    $display("t_fuse done");
  endtask : t_fuse

  // blown fuse locks the test port out while fuseBlown stays high
  task t_blown;
    set1(8'hff, 8'hff, 8'hff);
    fuseBlown = 1'h1;
    testEnable = 1'h1;
    wt(10);
    chk("blown flags", 8'h03, {4'h0, jtagTakeover, testAccessAllowed,
      jtagBypass, memReadBlock});
    chk("blown pins", 8'h03, {6'h0, port1_pin_oe[6:5]});
    $display("t_blown done");
  endtask : t_blown

  // ------------------------------------------------------------
  // main sequence and watchdog
  // ------------------------------------------------------------
  initial begin
    rst = 1'h1;
    clkEn = 1'h1;
    {testEnable, fuseBlown, toolActive, toolSel} = 4'h3;
    {src, ext1, ext2, extEn1, extEn2} = {16'hb3d7, 16'h0000, 16'hffff};
    {port1_out, port2_out, port1_direction, port2_direction} = 32'h0;
    {port1_function_select, port1_function_select_alt} = 16'h0000;
    {port2_function_select, port2_function_select_alt} = 16'hc000;
    do_reset;
    t_port1;
    t_freeze;
    t_port2;
    t_takeover;
    t_fuse;
    t_blown;
    end_sim;
  end

  initial begin
    repeat (3000) @(posedge core_clk);
    errors++;
    end_sim;
  end
endmodule : port_pin_function_mux_bench

// ---- sim/port_pin_function_mux_sva.sv ----
// assertion checker for the port pin function multiplexer
`timescale 1ns/1ps

module port_pin_function_mux_sva (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clkEn,
  input wire logic [7:0] port1_direction,
  input wire logic [7:0] port1_function_select,
  input wire logic [7:0] port1_function_select_alt,
  input wire logic [7:0] port1_out,
  input wire logic serial_transmit_line,
  input wire logic converter2_bitstream_out,
  input wire logic [7:0] port1_pin_in,
  input wire logic [7:0] port1_pin_out,
  input wire logic [7:0] port1_pin_oe,
  input wire logic [7:0] port2_pin_oe,
  input wire logic serial_receive_line,
  input wire logic jtagTakeover,
  input wire logic testAccessAllowed,
  input wire logic jtagBypass,
  input wire logic memReadBlock,
  input wire logic fuseCheckActive,
  input wire logic fuse_sense_current
);
  // ------------------------------------------------------------
  // helper state
  // ------------------------------------------------------------
  logic doneSeen; // fuse check has ended once since power-on
  // remembers the end so a later re-entry is caught
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      doneSeen <= 1'h0;
    end else if ($fell(fuseCheckActive)) begin
      doneSeen <= 1'h1;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  // a low enable freezes the registers, so next-cycle checks pause
  default disable iff (rst || !clkEn);
  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  gpio_follow_a: assert property (
    !port1_function_select[3] |=>
    port1_pin_oe[3] == $past(port1_direction[3]) &&
    (!port1_pin_oe[3] || port1_pin_out[3] == $past(port1_out[3])))
    else $error("pin 1.3 gpio drive wrong");
  tx_route_a: assert property (
    port1_function_select[3] && !port1_function_select_alt[3] |=>
    port1_pin_oe[3] && port1_pin_out[3] == $past(serial_transmit_line))
    else $error("pin 1.3 transmit route wrong");
  bitstream_out_a: assert property (
    port1_function_select[4] && port1_function_select_alt[4] &&
    port1_direction[4] |=> port1_pin_oe[4] &&
    port1_pin_out[4] == $past(converter2_bitstream_out))
    else $error("pin 1.4 bitstream route wrong");
  rx_path_a: assert property (
    port1_function_select[4] && !port1_function_select_alt[4] |=>
    !port1_pin_oe[4] && serial_receive_line == $past(port1_pin_in[4]))
    else $error("pin 1.4 receive route wrong");
  takeover_in_a: assert property (
    jtagTakeover ##1 jtagTakeover |->
    !port1_pin_oe[5] && !port1_pin_oe[6] && !port2_pin_oe[0])
    else $error("test pins driven under takeover");
  blown_bypass_a: assert property (
    jtagBypass |-> memReadBlock && !jtagTakeover && !testAccessAllowed)
    else $error("blown fuse still grants access");
  sense_gate_a: assert property (
    fuse_sense_current |-> fuseCheckActive || $past(fuseCheckActive))
    else $error("sense path on outside fuse check");
  no_reentry_a: assert property (
    doneSeen |-> !fuseCheckActive)
    else $error("fuse check entered again");
endmodule : port_pin_function_mux_sva

bind port_pin_function_mux port_pin_function_mux_sva
  port_pin_function_mux_sva_i (.*);

// ---- verilog/port_mux_map.svh ----
// constant map for the port pin function multiplexer
`ifndef PORT_MUX_MAP_SVH
`define PORT_MUX_MAP_SVH

// ----------------------------------------------------------------
// reset values and the edge count limit
// ----------------------------------------------------------------
`define PMX_BIT_LO 1'h0
`define PMX_BIT_HI 1'h1
`define PMX_EDGE_CNT_RST 2'h0
`define PMX_EDGE_CNT_MAX 2'h2
`define PMX_SYNC_RST 3'h7

// ----------------------------------------------------------------
// positions inside the port vectors
// ----------------------------------------------------------------
`define P1_TX_BIT 3
`define P1_RX_BIT 4
`define P1_MO_BIT 5
`define P1_MI_BIT 6
`define P1_CK_BIT 7
`define P2_STE_BIT 0
`define P2_XIN_BIT 6
`define P2_XOUT_BIT 7

`endif

// ---- verilog/port_mux_pkg.sv ----
// types shared by the port pin function multiplexer
package port_mux_pkg;

  // fuse check mode sequencing
  typedef enum logic [1:0] {
    FC_ARMED,
    FC_ACTIVE,
    FC_DONE
  } fuse_state_e;

  // per pin function selection
  typedef enum logic [1:0] {
    FN_GPIO,
    FN_PRIMARY,
    FN_SECONDARY,
    FN_NONE
  } pin_fn_e;

endpackage : port_mux_pkg

// ---- verilog/port_pin_function_mux.sv ----
// pin function multiplexer with test takeover and fuse check sequencer
`timescale 1ns/1ps
`include "port_mux_map.svh"

module port_pin_function_mux
  import port_mux_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clkEn,
  // port control bits
  input wire logic [7:0] port1_direction,
  input wire logic [7:0] port1_function_select,
  input wire logic [7:0] port1_function_select_alt,
  input wire logic [7:0] port2_direction,
  input wire logic [7:0] port2_function_select,
  input wire logic [7:0] port2_function_select_alt,
  // gpio output data from the port registers
  input wire logic [7:0] port1_out,
  input wire logic [7:0] port2_out,
  // peripheral sources
  input wire logic serial_transmit_line,
  input wire logic converter1_bitstream_out,
  input wire logic converter2_bitstream_out,
  input wire logic spi_master_out_line,
  input wire logic spi_master_in_out,
  input wire logic spi_master_in_oe,
  input wire logic serial_clock_out,
  input wire logic serial_clock_oe,
  input wire logic spi_master_out_oe,
  input wire logic supervisor_output,
  input wire logic timer_channel0_out,
  input wire logic timer_channel1_out,
  input wire logic timer_channel2_out,
  input wire logic test_data_out,
  input wire logic test_data_out_oe,
  input wire logic hf_crystal_output,
  // test control
  input wire logic jtagSelect,
  input wire logic testEnable,
  input wire logic fuseBlown,
  // pin side (input, output, output enable)
  input wire logic [7:0] port1_pin_in,
  input wire logic [7:0] port2_pin_in,
  output logic [7:0] port1_pin_out,
  output logic [7:0] port1_pin_oe,
  output logic [7:0] port2_pin_out,
  output logic [7:0] port2_pin_oe,
  // inputs routed back to the core
  output logic [7:0] port1_in,
  output logic [7:0] port2_in,
  output logic serial_receive_line,
  output logic spi_master_in_line,
  output logic spi_master_out_in,
  output logic serial_clock_in,
  output logic spi_slave_transmit_enable,
  output logic hf_crystal_input,
  output logic test_mode_select,
  output logic test_clock_in,
  output logic test_data_in,
  output logic test_clock_input,
  // test and fuse status
  output logic jtagTakeover,
  output logic testAccessAllowed,
  output logic jtagBypass,
  output logic memReadBlock,
  output logic fuseCheckActive,
  output logic fuse_sense_current
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // shared four-way selection decode; used by every muxed pin but the crystal pins
  function automatic pin_fn_e decode_fn(input logic dir, input logic sel,
                                        input logic alt);
    if (!sel) begin
      return FN_GPIO;
    end else if (!alt) begin
      return FN_PRIMARY; // direction ignored here
    end else if (dir) begin
      return FN_SECONDARY;
    end else begin
      return FN_NONE; // undocumented combination: pin parked
    end
  endfunction : decode_fn

  // ----------------------------------------------------------------
  // pin input synchronisers
  // ----------------------------------------------------------------
  logic [2:0] tmsSync; // mode select pin, three stages
  logic [2:0] tenSync; // test enable pin
  logic [2:0] blowSync; // fuse blown level
  logic tmsLevel; // filtered mode select level
  logic tenLevel; // filtered test enable level
  logic blowLevel; // filtered fuse blown level
  logic tmsPrev; // last filtered mode select level

  // stage one feeds only stage two; agreement of two and three counts
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tmsSync <= `PMX_SYNC_RST;
      tenSync <= 3'h0;
      blowSync <= 3'h0;
    end else if (clkEn) begin
      tmsSync <= {tmsSync[1:0], jtagSelect};
      tenSync <= {tenSync[1:0], testEnable};
      blowSync <= {blowSync[1:0], fuseBlown};
    end
  end

  // filtered levels move only when the last two stages agree
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tmsLevel <= `PMX_BIT_HI;
      tmsPrev <= `PMX_BIT_HI;
      tenLevel <= `PMX_BIT_LO;
      blowLevel <= `PMX_BIT_LO;
    end else if (clkEn) begin
      if (tmsSync[1] == tmsSync[2]) begin
        tmsLevel <= tmsSync[2];
      end
      if (tenSync[1] == tenSync[2]) begin
        tenLevel <= tenSync[2];
      end
      if (blowSync[1] == blowSync[2]) begin
        blowLevel <= blowSync[2];
      end
      tmsPrev <= tmsLevel;
    end
  end

  // ----------------------------------------------------------------
  // fuse check sequencer
  // ----------------------------------------------------------------
  fuse_state_e fuseState; // sequencer state
  logic [1:0] riseCount; // select rises seen since power-on
  logic startDone; // first filtered sample after reset taken
  logic tmsFall; // filtered falling edge
  logic tmsRise; // filtered rising edge

  assign tmsFall = tmsPrev & ~tmsLevel;
  assign tmsRise = ~tmsPrev & tmsLevel;

  // test enable falling edge ends a session
  logic tenPrev; // last filtered test enable level
  logic tenFall; // filtered falling edge of test enable
  assign tenFall = tenPrev & ~tenLevel;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tenPrev <= `PMX_BIT_LO;
    end else if (clkEn) begin
      tenPrev <= tenLevel;
    end
  end

  // rst is the power-on reset: only it re-arms the sequencer
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      fuseState <= FC_ARMED;
      riseCount <= `PMX_EDGE_CNT_RST;
      startDone <= `PMX_BIT_LO;
    end else if (clkEn) begin
      startDone <= `PMX_BIT_HI;
      if (tmsRise && riseCount != `PMX_EDGE_CNT_MAX) begin
        riseCount <= riseCount + 2'h1;
      end
      case (fuseState)
        FC_ARMED: begin
          // held low at power-up shows as a filtered fall once settled
          if (tmsFall || (!startDone && !tmsSync[2] && !tmsSync[1])) begin
            fuseState <= FC_ACTIVE;
          end
        end
        FC_ACTIVE: begin
          if (tmsRise && riseCount == 2'h1) begin
            fuseState <= FC_DONE;
          end else if (tenFall) begin
            fuseState <= FC_DONE; // session over
          end
        end
        FC_DONE: begin
          fuseState <= FC_DONE; // sticky until power-on reset
        end
        default: begin
          fuseState <= FC_DONE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // test access and protection
  // ----------------------------------------------------------------
  // takeover needs test enable; a blown fuse refuses it outright
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      jtagTakeover <= `PMX_BIT_LO;
      testAccessAllowed <= `PMX_BIT_LO;
      jtagBypass <= `PMX_BIT_LO;
      memReadBlock <= `PMX_BIT_LO;
      fuseCheckActive <= `PMX_BIT_LO;
      fuse_sense_current <= `PMX_BIT_LO;
    end else if (clkEn) begin
      jtagTakeover <= tenLevel & ~blowLevel;
      testAccessAllowed <= ~blowLevel;
      jtagBypass <= blowLevel;
      memReadBlock <= blowLevel;
      fuseCheckActive <= (fuseState == FC_ACTIVE) & ~tenFall;
      // sense current only in active mode with select low
      fuse_sense_current <= (fuseState == FC_ACTIVE) & ~tenFall
                            & ~tmsLevel;
    end
  end

  // ----------------------------------------------------------------
  // combinational function decode
  // ----------------------------------------------------------------
  pin_fn_e fn1 [8]; // port 1 per-pin function
  pin_fn_e fn2 [8]; // port 2 per-pin function

  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_dec
      assign fn1[g] = decode_fn(port1_direction[g], port1_function_select[g],
                                port1_function_select_alt[g]);
      assign fn2[g] = decode_fn(port2_direction[g], port2_function_select[g],
                                port2_function_select_alt[g]);
    end
  endgenerate

  logic [7:0] next_p1Out; // next port 1 pin data
  logic [7:0] next_p1Oe; // next port 1 pin enable
  logic [7:0] next_p2Out; // next port 2 pin data
  logic [7:0] next_p2Oe; // next port 2 pin enable
  logic tk; // takeover as seen by the decode

  assign tk = jtagTakeover;

  // output side: gpio default, then per-pin overrides
  always_comb begin
    next_p1Out = port1_out;
    next_p1Oe = port1_direction;
    next_p2Out = port2_out;
    next_p2Oe = port2_direction;
    // pin 1.3
    if (fn1[`P1_TX_BIT] == FN_PRIMARY) begin
      next_p1Out[`P1_TX_BIT] = serial_transmit_line;
      next_p1Oe[`P1_TX_BIT] = 1'b1;
    end else if (fn1[`P1_TX_BIT] == FN_SECONDARY) begin
      next_p1Out[`P1_TX_BIT] = converter1_bitstream_out;
    end else if (fn1[`P1_TX_BIT] == FN_NONE) begin
      next_p1Oe[`P1_TX_BIT] = 1'b0;
    end
    // pin 1.4: receive is an input
    if (fn1[`P1_RX_BIT] == FN_PRIMARY) begin
      next_p1Oe[`P1_RX_BIT] = 1'b0;
    end else if (fn1[`P1_RX_BIT] == FN_SECONDARY) begin
      next_p1Out[`P1_RX_BIT] = converter2_bitstream_out;
    end else if (fn1[`P1_RX_BIT] == FN_NONE) begin
      next_p1Oe[`P1_RX_BIT] = 1'b0;
    end
    // pins 1.5 to 1.7, spi lines bidirectional per spi role
    if (fn1[`P1_MO_BIT] == FN_PRIMARY) begin
      next_p1Out[`P1_MO_BIT] = spi_master_out_line;
      next_p1Oe[`P1_MO_BIT] = spi_master_out_oe;
    end else if (fn1[`P1_MO_BIT] == FN_SECONDARY) begin
      next_p1Out[`P1_MO_BIT] = supervisor_output;
    end else if (fn1[`P1_MO_BIT] == FN_NONE) begin
      next_p1Oe[`P1_MO_BIT] = 1'b0;
    end
    if (fn1[`P1_MI_BIT] == FN_PRIMARY) begin
      next_p1Out[`P1_MI_BIT] = spi_master_in_out;
      next_p1Oe[`P1_MI_BIT] = spi_master_in_oe;
    end else if (fn1[`P1_MI_BIT] == FN_SECONDARY) begin
      next_p1Out[`P1_MI_BIT] = timer_channel2_out;
    end else if (fn1[`P1_MI_BIT] == FN_NONE) begin
      next_p1Oe[`P1_MI_BIT] = 1'b0;
    end
    if (fn1[`P1_CK_BIT] == FN_PRIMARY) begin
      next_p1Out[`P1_CK_BIT] = serial_clock_out;
      next_p1Oe[`P1_CK_BIT] = serial_clock_oe;
    end else if (fn1[`P1_CK_BIT] == FN_SECONDARY) begin
      next_p1Out[`P1_CK_BIT] = timer_channel1_out;
    end else if (fn1[`P1_CK_BIT] == FN_NONE) begin
      next_p1Oe[`P1_CK_BIT] = 1'b0;
    end
    // pin 2.0
    if (fn2[`P2_STE_BIT] == FN_PRIMARY) begin
      next_p2Oe[`P2_STE_BIT] = 1'b0;
    end else if (fn2[`P2_STE_BIT] == FN_SECONDARY) begin
      next_p2Out[`P2_STE_BIT] = timer_channel0_out;
    end else if (fn2[`P2_STE_BIT] == FN_NONE) begin
      next_p2Oe[`P2_STE_BIT] = 1'b0;
    end
    // crystal pins: select with direction 0 gives the oscillator
    if (port2_function_select[`P2_XIN_BIT]) begin
      next_p2Oe[`P2_XIN_BIT] = 1'b0;
    end
    if (port2_function_select[`P2_XOUT_BIT]) begin
      next_p2Out[`P2_XOUT_BIT] = hf_crystal_output;
      next_p2Oe[`P2_XOUT_BIT] = ~port2_direction[`P2_XOUT_BIT];
    end
    // takeover wins over every select and direction bit of pins 1.5 to 1.7 and 2.0
    if (tk) begin
      next_p1Oe[`P1_MO_BIT] = 1'b0;
      next_p1Oe[`P1_MI_BIT] = 1'b0;
      next_p1Out[`P1_CK_BIT] = test_data_out;
      next_p1Oe[`P1_CK_BIT] = test_data_out_oe;
      next_p2Oe[`P2_STE_BIT] = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // registered pin and core side outputs
  // ----------------------------------------------------------------
  // one register stage keeps every top output flop driven; the decode
  // itself has no memory. crystal pins reset undriven, like every other pin.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      port1_pin_out <= 8'h00;
      port1_pin_oe <= 8'h00;
      port2_pin_out <= 8'h00;
      port2_pin_oe <= 8'h00;
    end else if (clkEn) begin
      port1_pin_out <= next_p1Out;
      port1_pin_oe <= next_p1Oe;
      port2_pin_out <= next_p2Out;
      port2_pin_oe <= next_p2Oe;
    end
  end

  // inputs back to peripherals; unselected ones idle low, but receive, slave transmit enable and mode select idle high
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      port1_in <= 8'h00;
      port2_in <= 8'h00;
      serial_receive_line <= `PMX_BIT_HI;
      spi_master_in_line <= `PMX_BIT_LO;
      spi_master_out_in <= `PMX_BIT_LO;
      serial_clock_in <= `PMX_BIT_LO;
      spi_slave_transmit_enable <= `PMX_BIT_HI;
      hf_crystal_input <= `PMX_BIT_LO;
      test_mode_select <= `PMX_BIT_HI;
      test_clock_in <= `PMX_BIT_LO;
      test_data_in <= `PMX_BIT_LO;
      test_clock_input <= `PMX_BIT_LO;
    end else if (clkEn) begin
      port1_in <= port1_pin_in;
      port2_in <= port2_pin_in;
      serial_receive_line <= (fn1[`P1_RX_BIT] == FN_PRIMARY)
                             ? port1_pin_in[`P1_RX_BIT] : 1'b1;
      spi_master_in_line <= (!tk && fn1[`P1_MI_BIT] == FN_PRIMARY)
                            & port1_pin_in[`P1_MI_BIT];
      spi_master_out_in <= (!tk && fn1[`P1_MO_BIT] == FN_PRIMARY)
                           & port1_pin_in[`P1_MO_BIT];
      serial_clock_in <= (!tk && fn1[`P1_CK_BIT] == FN_PRIMARY)
                         & port1_pin_in[`P1_CK_BIT];
      spi_slave_transmit_enable <= (!tk && fn2[`P2_STE_BIT] == FN_PRIMARY)
                                   ? port2_pin_in[`P2_STE_BIT] : 1'b1;
      hf_crystal_input <= port2_function_select[`P2_XIN_BIT]
                          & ~port2_direction[`P2_XIN_BIT]
                          & port2_pin_in[`P2_XIN_BIT];
      test_mode_select <= tk ? port1_pin_in[`P1_MO_BIT] : 1'b1;
      test_clock_in <= tk & port1_pin_in[`P1_MI_BIT];
      test_data_in <= tk & port2_pin_in[`P2_STE_BIT];
      test_clock_input <= tk & port2_pin_in[`P2_STE_BIT];
    end
  end

endmodule : port_pin_function_mux
